/* File: swc_pkg.sv */
// package: constants and carriers of the sleep and wake-up controller
package swc_pkg;
    // ********************************************
    // bus and register map
    // ********************************************
    localparam int ADDR_W = 16;
    // word indices; byte address is four times the index
    localparam logic [13:0] IDX_STATUS = 14'h0003;
    localparam logic [13:0] IDX_INTCTL = 14'h000b;
    localparam logic [13:0] IDX_OPTION = 14'h0081;
    localparam logic [13:0] IDX_IRQEN = 14'h008c;
    localparam logic [13:0] IDX_FUSE = 14'h2007;
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [6:0] IRQEN_RST = 7'h00;
    localparam logic [7:0] FUSE_DEF = 8'hff;
    // ********************************************
    // field positions
    // ********************************************
    localparam int ST_ASLEEP_BIT = 0;
    localparam int ST_OST_BIT = 1;
    localparam int ST_PD_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int IC_EDGEF_BIT = 1;
    localparam int IC_EDGEEN_BIT = 4;
    localparam int IC_GIE_BIT = 7;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_EDGE_BIT = 6;
    localparam int FUSE_WATCHDOG_ENABLE_FUSE_BIT = 2;
    localparam logic [1:0] FOSC_RC = 2'b11;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    // ********************************************
    // timing
    // ********************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_PERIOD_NS = 25;
    localparam int OST_TOSC = 1024;
    localparam int OST_CYCLES = OST_TOSC * OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int WDT_PERIOD_US = 18000;
    localparam int WDT_CYCLES_DEF = WDT_PERIOD_US * 1000 / CLK_PERIOD_NS;
    // ********************************************
    // types
    // ********************************************
    typedef enum logic [1:0] {
        SWC_RUN = 2'b00,
        SWC_SLEEP = 2'b01,
        SWC_OST = 2'b11
    } swc_state_t;
    typedef struct packed {
        logic portChange;
        logic timer1Ovf;
        logic sspStartStop;
        logic sspSlaveXfer;
        logic captureEvt;
        logic pspAccess;
        logic usartSyncSlave;
    } swc_wake_t;
    typedef struct packed {
        logic sleepInstr;
        logic clrwdtInstr;
    } swc_core_req_t;
    typedef struct packed {
        logic fetchHalt;
        logic prefetchNext;
        logic resumePulse;
        logic vectorAfterNext;
        logic oscDriverOn;
        logic phaseClkOn;
        logic ioHold;
        logic deviceReset;
    } swc_core_out_t;
endpackage : swc_pkg

/* File: swc_sleep_wakeup_control.sv */
// module: sleep entry, watchdog and wake-up control of the core
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module swc_sleep_wakeup_control #(
    parameter int WDT_CYCLES = swc_pkg::WDT_CYCLES_DEF,
    parameter logic [7:0] FUSE_WORD = swc_pkg::FUSE_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [swc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic masterResetN,
    input wire logic edgeIrqPin,
    input wire swc_pkg::swc_wake_t wakeFlags,
    input wire logic timer1Async,
    input wire logic otherIrq,
    output logic otherIrqGated,
    input wire swc_pkg::swc_core_req_t coreReq,
    output swc_pkg::swc_core_out_t coreOut,
    output logic [12:0] vectorAddr
);
    import swc_pkg::*;

    localparam int BW = $clog2(WDT_CYCLES + 1);
    localparam int OW = $clog2(OST_CYCLES + 1);
    localparam logic [BW-1:0] WDT_LAST = BW'(WDT_CYCLES - 1);
    localparam logic [OW-1:0] OST_LAST = OW'(OST_CYCLES - 1);

    swc_state_t state_q;
    logic [7:0] option_q;
    logic [6:0] irqEn_q;
    logic gie_q;
    logic edgeEn_q;
    logic edgeFlag_q;
    logic edgePin_q;
    logic pd_q;
    logic to_q;
    logic pend_q;
    logic vec_q;
    logic resume_q;
    logic prefetch_q;
    logic devReset_q;
    logic [BW-1:0] wdtBase_q;
    logic [6:0] wdtPre_q;
    logic [OW-1:0] ost_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ********************************************
    // bus decode
    // ********************************************
    logic busReq;
    logic wrEn;
    logic [13:0] idx;
    assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wrEn = busReq & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[15:2];

    // ********************************************
    // wake sources
    // ********************************************
    logic edgeHit;
    logic edgeIrq;
    logic [6:0] wakeVec;
    logic periphWake;
    logic irqWake;
    logic rstAll;
    logic sleepTaken;
    logic wdtTick;
    logic wdtTimeout;
    logic wdtClear;
    logic [6:0] psMax;
    logic wdtEn;
    logic rcMode;

    assign rstAll = ~nrst | ~masterResetN;
    assign wdtEn = FUSE_WORD[FUSE_WATCHDOG_ENABLE_FUSE_BIT];
    assign rcMode = FUSE_WORD[1:0] == FOSC_RC;
    assign edgeHit = option_q[OPT_EDGE_BIT] ? (edgeIrqPin & ~edgePin_q)
                                            : (~edgeIrqPin & edgePin_q);
    assign edgeIrq = edgeFlag_q & edgeEn_q;
    // timer1 only counts asleep when asynchronous
    assign wakeVec = {wakeFlags.portChange,
                      wakeFlags.timer1Ovf & timer1Async,
                      wakeFlags.sspStartStop,
                      wakeFlags.sspSlaveXfer,
                      wakeFlags.captureEvt,
                      wakeFlags.pspAccess,
                      wakeFlags.usartSyncSlave};
    assign periphWake = |(wakeVec & irqEn_q);
    assign irqWake = edgeIrq | periphWake;
    assign otherIrqGated = otherIrq & (state_q == SWC_RUN);

    assign sleepTaken = (state_q == SWC_RUN) & coreReq.sleepInstr
                        & ~pend_q;

    // ********************************************
    // watchdog
    // ********************************************
    assign psMax = 7'((8'h01 << option_q[2:0]) - 8'h01);
    assign wdtTick = wdtEn & (wdtBase_q == WDT_LAST);
    assign wdtTimeout = wdtTick & (~option_q[OPT_PSA_BIT]
                                   | (wdtPre_q == psMax));
    assign wdtClear = coreReq.clrwdtInstr | sleepTaken
                      | wdtTimeout;

    always_ff @(posedge core_clk) begin
        if (rstAll | wdtClear) begin
            wdtBase_q <= '0;
            wdtPre_q <= '0;
        end else if (wdtEn) begin
            if (wdtTick) begin
                wdtBase_q <= '0;
                wdtPre_q <= wdtPre_q + 7'h01;
            end else begin
                wdtBase_q <= wdtBase_q + BW'(1);
            end
        end
    end

    // ********************************************
    // edge pin flag
    // ********************************************
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            // track the pin level so a high pin gives no false edge
            edgePin_q <= edgeIrqPin;
            edgeFlag_q <= 1'b0;
        end else begin
            edgePin_q <= edgeIrqPin;
            // a new edge beats the software clear
            if (edgeHit) begin
                edgeFlag_q <= 1'b1;
            end else if (wrEn && idx == IDX_INTCTL
                         && wb_dat_i[IC_EDGEF_BIT]) begin
                edgeFlag_q <= 1'b0;
            end
        end
    end

    // decides no-op sleep from flags set before the instruction
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= irqWake;
        end
    end

    // ********************************************
    // sleep state machine
    // ********************************************
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            state_q <= SWC_RUN;
            ost_q <= '0;
            vec_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            resume_q <= 1'b0;
            case (state_q)
                SWC_RUN: begin
                    if (sleepTaken) begin
                        state_q <= SWC_SLEEP;
                    end
                end
                SWC_SLEEP: begin
                    // reached only after one full asleep cycle
                    if (wdtTimeout | irqWake) begin
                        vec_q <= gie_q & irqWake & ~wdtTimeout;
                        ost_q <= '0;
                        if (rcMode) begin
                            state_q <= SWC_RUN;
                            resume_q <= 1'b1;
                        end else begin
                            state_q <= SWC_OST;
                        end
                    end
                end
                SWC_OST: begin
                    if (ost_q == OST_LAST) begin
                        state_q <= SWC_RUN;
                        resume_q <= 1'b1;
                    end else begin
                        ost_q <= ost_q + OW'(1);
                    end
                end
                default: begin
                    state_q <= SWC_RUN;
                end
            endcase
        end
    end

    // ********************************************
    // status flags
    // ********************************************
    // pin reset keeps the flags so software can see the cause
    always_ff @(posedge core_clk) begin
        if (~nrst) begin
            pd_q <= 1'b1;
            to_q <= 1'b1;
        end else if (masterResetN) begin
            if (sleepTaken) begin
                pd_q <= 1'b0;
                to_q <= 1'b1;
            end else if (wdtTimeout) begin
                to_q <= 1'b0;
            end
        end
    end

    // ********************************************
    // core side pulses
    // ********************************************
    always_ff @(posedge core_clk) begin
        if (~nrst) begin
            prefetch_q <= 1'b0;
            devReset_q <= 1'b0;
        end else begin
            prefetch_q <= (state_q == SWC_RUN)
                          & coreReq.sleepInstr;
            // watchdog resets only while running; asleep it wakes
            devReset_q <= ~masterResetN
                          | (wdtTimeout & (state_q == SWC_RUN));
        end
    end

    always_comb begin
        coreOut.fetchHalt = state_q != SWC_RUN;
        coreOut.prefetchNext = prefetch_q;
        coreOut.resumePulse = resume_q;
        coreOut.vectorAfterNext = resume_q & vec_q;
        coreOut.oscDriverOn = state_q != SWC_SLEEP;
        coreOut.phaseClkOn = state_q == SWC_RUN;
        coreOut.ioHold = state_q != SWC_RUN;
        coreOut.deviceReset = devReset_q;
    end
    assign vectorAddr = VECTOR_ADDR;

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            option_q <= OPTION_RST;
            irqEn_q <= IRQEN_RST;
            gie_q <= 1'b0;
            edgeEn_q <= 1'b0;
        end else if (wrEn) begin
            case (idx)
                IDX_OPTION: option_q <= wb_dat_i[7:0];
                IDX_IRQEN: irqEn_q <= wb_dat_i[6:0];
                IDX_INTCTL: begin
                    gie_q <= wb_dat_i[IC_GIE_BIT];
                    edgeEn_q <= wb_dat_i[IC_EDGEEN_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (~nrst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= busReq;
            if (busReq) begin
                dat_q <= '0;
                case (idx)
                    IDX_STATUS: begin
                        dat_q[ST_TO_BIT] <= to_q;
                        dat_q[ST_PD_BIT] <= pd_q;
                        dat_q[ST_OST_BIT] <= state_q == SWC_OST;
                        dat_q[ST_ASLEEP_BIT] <= state_q == SWC_SLEEP;
                    end
                    IDX_INTCTL: begin
                        dat_q[IC_GIE_BIT] <= gie_q;
                        dat_q[IC_EDGEEN_BIT] <= edgeEn_q;
                        dat_q[IC_EDGEF_BIT] <= edgeFlag_q;
                    end
                    IDX_OPTION: dat_q[7:0] <= option_q;
                    IDX_IRQEN: dat_q[6:0] <= irqEn_q;
                    IDX_FUSE: dat_q[7:0] <= FUSE_WORD;
                    default: dat_q <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : swc_sleep_wakeup_control

/* File: swc_sleep_wakeup_control_checker.sv */
// checker: port-level assertions of the sleep and wake-up controller
`timescale 1ns/100ps
module swc_sleep_wakeup_control_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic masterResetN,
    input wire logic otherIrq,
    input wire logic otherIrqGated,
    input wire swc_pkg::swc_core_req_t coreReq,
    input wire swc_pkg::swc_core_out_t coreOut,
    input wire logic [12:0] vectorAddr
);
    import swc_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // ****
    // halt, wake and gating
    // ****
    property p_enter;
        $rose(coreOut.fetchHalt) |-> $past(coreReq.sleepInstr); endproperty
    a_enter: assert property (p_enter) else $error("halt uncaused");
    property p_osc;
        $rose(coreOut.fetchHalt) |-> !coreOut.oscDriverOn; endproperty
    a_osc: assert property (p_osc) else $error("osc left on");
    property p_pre;
        coreReq.sleepInstr && !coreOut.fetchHalt |=> coreOut.prefetchNext;
    endproperty
    a_pre: assert property (p_pre) else $error("no prefetch");
    property p_leave;
        $fell(coreOut.fetchHalt) |-> coreOut.resumePulse || !$past(masterResetN);
    endproperty
    a_leave: assert property (p_leave) else $error("silent wake");
    property p_pin;
        !masterResetN |=> coreOut.deviceReset && !coreOut.fetchHalt; endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed");
    property p_gate;
        otherIrqGated == (otherIrq && coreOut.phaseClkOn); endproperty
    a_gate: assert property (p_gate) else $error("irq not gated");
    property p_vec;
        coreOut.vectorAfterNext |-> coreOut.resumePulse
            && vectorAddr == VECTOR_ADDR; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_res;
        coreOut.resumePulse |-> $past(coreOut.fetchHalt)
            && coreOut.oscDriverOn && !coreOut.ioHold; endproperty
    a_res: assert property (p_res) else $error("bad resume");
    c_sleep: cover property ($rose(coreOut.fetchHalt));
    c_vec: cover property (coreOut.vectorAfterNext);
    c_rst: cover property (coreOut.deviceReset);
endmodule : swc_sleep_wakeup_control_checker
bind swc_sleep_wakeup_control swc_sleep_wakeup_control_checker swc_chk_inst (
    .core_clk(core_clk), .nrst(nrst), .masterResetN(masterResetN),
    .otherIrq(otherIrq), .otherIrqGated(otherIrqGated),
    .coreReq(coreReq), .coreOut(coreOut), .vectorAddr(vectorAddr));

/* File: swc_core_model.sv */
// partner: core model issuing watchdog clear then sleep
`timescale 1ns/100ps
module swc_core_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sleepCmd,
    input wire logic fetchHalt,
    output swc_pkg::swc_core_req_t coreReq
);
    import swc_pkg::*;
    logic [1:0] seq_q;
    // ****
    // instruction issue
    // ****
    // a halted core fetches nothing, so commands are dropped while halted
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            seq_q <= 2'h0;
            coreReq <= '0;
        end else begin
            coreReq.clrwdtInstr <= sleepCmd && !fetchHalt;
            // the slot after sleep issues nothing, as a no-op would
            coreReq.sleepInstr <= seq_q == 2'h1;
            if (sleepCmd && !fetchHalt) begin
                seq_q <= 2'h2;
            end else if (seq_q != 2'h0) begin
                seq_q <= seq_q - 2'h1;
            end
        end
    end
endmodule : swc_core_model

/* File: swc_testbench.sv */
// bench: scenarios for the sleep and wake-up controller
`timescale 1ns/100ps
module testbench;
    import swc_pkg::*;
    logic core_clk, nrst, cyc, stb, we, ack, masterResetN, edgeIrqPin;
    logic timer1Async, otherIrq, otherIrqGated, sleepCmd, s, v;
    logic [15:0] adr;
    logic [31:0] dati, dato;
    logic [12:0] vectorAddr;
    logic [7:0] rd;
    swc_wake_t wakeFlags;
    swc_core_req_t coreReq;
    swc_core_out_t coreOut, coreOut2;
    int err_total, n_checks;
    // short watchdog keeps timeout scenarios brief
    swc_sleep_wakeup_control #(.WDT_CYCLES(20))
    swc_sleep_wakeup_control_inst (
        .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dati),
        .wb_dat_o(dato), .wb_ack_o(ack), .masterResetN(masterResetN),
        .edgeIrqPin(edgeIrqPin), .wakeFlags(wakeFlags),
        .timer1Async(timer1Async), .otherIrq(otherIrq),
        .otherIrqGated(otherIrqGated), .coreReq(coreReq),
        .coreOut(coreOut), .vectorAddr(vectorAddr));
    // crystal-mode twin shares every input; only its start-up wait and its vector are judged
    swc_sleep_wakeup_control #(.WDT_CYCLES(20), .FUSE_WORD(8'hfc))
    swc_sleep_wakeup_control_ost_inst (
        .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dati),
        .wb_dat_o(), .wb_ack_o(), .masterResetN(masterResetN),
        .edgeIrqPin(edgeIrqPin), .wakeFlags(wakeFlags),
        .timer1Async(timer1Async), .otherIrq(otherIrq),
        .otherIrqGated(), .coreReq(coreReq),
        .coreOut(coreOut2), .vectorAddr());
    swc_core_model swc_core_model_inst (.core_clk(core_clk), .nrst(nrst),
        .sleepCmd(sleepCmd), .fetchHalt(coreOut.fetchHalt),
        .coreReq(coreReq));
    // ****
    // shared tasks
    // ****
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task hang(input string nm);
        chk(nm, 8'h01, 8'h00);
        report_and_stop();
    endtask : hang
    task wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dati <= {24'h0, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) hang("bus ack");
        rd = dato[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task st(input logic [7:0] e);
        wb(1'b0, IDX_STATUS, 8'h00);
        chk("status", e, rd & 8'h1b);
    endtask : st
    // waits for resume, or for a device reset when r is set
    task wres(input logic r, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((r ? coreOut.deviceReset : coreOut.resumePulse) !== 1'b1
            && n < lim);
        if ((r ? coreOut.deviceReset : coreOut.resumePulse) !== 1'b1)
            hang("wake");
        v = coreOut.vectorAfterNext;
    endtask : wres
    // late flags rise on the edge that takes the sleep instruction
    task go_sleep(input swc_wake_t late);
        int n;
        @(posedge core_clk);
        sleepCmd <= 1'b1;
        @(posedge core_clk);
        sleepCmd <= 1'b0;
        n = 0;
        while (coreReq.sleepInstr !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        if (coreReq.sleepInstr !== 1'b1) hang("sleep issue");
        @(posedge core_clk);
        wakeFlags <= wakeFlags | late;
        @(negedge core_clk);
        s = coreOut.fetchHalt;
    endtask : go_sleep
    // ****
    // scenarios
    // ****
    task t_regs;
        st(8'h18);
        wb(1'b0, IDX_OPTION, 8'h00);
        chk("option", OPTION_RST, rd);
        wb(1'b1, IDX_FUSE, 8'h00);
        wb(1'b0, IDX_FUSE, 8'h00);
        chk("fuse", FUSE_DEF, rd);
        wb(1'b1, IDX_IRQEN, 8'hff);
        wb(1'b0, IDX_IRQEN, 8'h00);
        chk("irqen", 8'h7f, rd);
        wb(1'b1, 14'h0100, 8'h55);
        wb(1'b0, 14'h0100, 8'h00);
        chk("unmapped", 8'h00, rd);
        $display("registers done");
    endtask : t_regs
    task t_early;
        wb(1'b1, IDX_IRQEN, 8'h01);
        wakeFlags <= 7'h01;
        go_sleep('0);
        chk("halt", 8'h00, {7'h0, s});
        st(8'h18);
        wakeFlags <= 7'h00;
        go_sleep(7'h01);
        chk("halt", 8'h01, {7'h0, s});
        wres(1'b0, 10);
        st(8'h10);
        wakeFlags <= 7'h00;
        $display("early and late flag done");
    endtask : t_early
    task t_flags;
        timer1Async <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, IDX_INTCTL, {i[0], 7'h00});
            wb(1'b1, IDX_IRQEN, 8'h01 << i);
            go_sleep('0);
            chk("hold", 8'h01, {7'h0, coreOut.ioHold});
            st(8'h11);
            wakeFlags <= 7'h01 << i;
            wres(1'b0, 10);
            chk("vector", {7'h0, i[0]}, {7'h0, v});
            @(posedge core_clk);
            wakeFlags <= 7'h00;
        end
        $display("wake sources done");
    endtask : t_flags
    task t_block;
        wb(1'b1, IDX_IRQEN, 8'h20);
        timer1Async <= 1'b0;
        go_sleep('0);
        @(posedge core_clk);
        wakeFlags <= 7'h60;
        otherIrq <= 1'b1;
        edgeIrqPin <= 1'b1;
        repeat (40) @(negedge core_clk);
        chk("halt", 8'h01, {7'h0, coreOut.fetchHalt});
        chk("gated", 8'h00, {7'h0, otherIrqGated});
        @(posedge core_clk);
        masterResetN <= 1'b0;
        @(posedge core_clk);
        masterResetN <= 1'b1;
        wres(1'b1, 5);
        chk("halt", 8'h00, {7'h0, coreOut.fetchHalt});
        st(8'h10);
        wakeFlags <= 7'h00;
        otherIrq <= 1'b0;
        edgeIrqPin <= 1'b0;
        wb(1'b1, IDX_INTCTL, 8'h02);
        $display("blocked sources and pin reset done");
    endtask : t_block
    task t_edge;
        int n;
        wb(1'b1, IDX_INTCTL, 8'h90);
        go_sleep('0);
        @(posedge core_clk);
        edgeIrqPin <= 1'b1;
        wres(1'b0, 10);
        chk("vector", 8'h01, {7'h0, v});
        // crystal twin woke on the same edge and waits out its start-up
        n = 0;
        while (coreOut2.resumePulse !== 1'b1 && n < 1100) begin
            @(negedge core_clk);
            n++;
        end
        if (coreOut2.resumePulse !== 1'b1) hang("ost wake");
        chk("ost wait", 8'h01, {7'h0, n == OST_CYCLES});
        chk("ost vector", 8'h01, {7'h0, coreOut2.vectorAfterNext});
        @(posedge core_clk);
        edgeIrqPin <= 1'b0;
        wb(1'b1, IDX_INTCTL, 8'h02);
        $display("edge pin done");
    endtask : t_edge
    task t_wdt;
        masterResetN <= 1'b0;
        @(posedge core_clk);
        masterResetN <= 1'b1;
        wb(1'b1, IDX_OPTION, 8'h00);
        go_sleep('0);
        wres(1'b0, 40);
        chk("vector", 8'h00, {7'h0, v});
        st(8'h00);
        wres(1'b1, 40);
        $display("watchdog done");
    endtask : t_wdt
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        nrst = 1'b0;
        {cyc, stb, we, sleepCmd, edgeIrqPin, otherIrq} = 6'h00;
        adr = 16'h0000;
        dati = 32'h0;
        wakeFlags = 7'h00;
        timer1Async = 1'b0;
        masterResetN = 1'b1;
        err_total = 0;
        n_checks = 0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_regs();
        t_early();
        t_flags();
        t_block();
        t_edge();
        t_wdt();
        report_and_stop();
    end
endmodule : testbench
